// file: tb/sbc_host_model.sv
`timescale 1ns/1ps
// host side of the management port; drives off the falling edge, one strobe per access
module sbc_host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // write strobe spans exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_wdata = ~d; // released data must not look valid
    endtask
    // read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // pending voltage code only moves through the commit register
    task automatic commit(input logic dchg);
        wr(sbc_pkg::OFS_COMMIT, {6'h00, dchg, 1'b1});
    endtask
endmodule // sbc_host_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import sbc_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sbc_row_t;
    localparam int BC = 20;
    logic clk_sys, reset, reg_wr, reg_rd, pf_n, cd, blank, hyst, ll;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0] sw_en, sw_on, dis;
    logic [1:0] l3, l2;
    logic [10:0] m3, m2, mv;
    logic [5:0] vc;
    int n_tests = 0;
    int num_errors = 0;
    int i;
    logic [10:0] ma[4] = '{11'd100, 11'd200, 11'd500, 11'd1000};
    logic [5:0] cv[4] = '{6'h00, 6'h32, 6'h33, 6'h3f};
    // reserved bits masked, unmapped and commit offsets read zero
    sbc_row_t rows[5] = '{'{8'h15, 8'hff, 8'h3f}, '{8'h14, 8'hff, 8'h4f},
        '{8'h16, 8'hff, 8'hbf}, '{8'h1a, 8'h00, 8'h00}, '{8'h10, 8'hff, 8'h00}};
    sbc_host_model h (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sbc_cfg_regs #(.BLANK_CYC(BC)) sbc_cfg_regs_i (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_fail_out_n(pf_n), .sw_enable(sw_en), .sw_on(sw_on),
        .sw_discharge(dis), .third_switch_current_limit(l3),
        .second_switch_current_limit(l2), .third_limit_ma(m3), .second_limit_ma(m2),
        .undervoltage_hysteresis_sel(hyst), .buck_light_load(ll), .buck_vcode(vc),
        .buck_vout_mv(mv), .buck_commit_discharge(cd), .buck_monitor_blank(blank));
    // 25 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // expected millivolts: fine steps up to the knee, coarse above it
    function automatic logic [10:0] exp_mv(input logic [5:0] c);
        return (c <= 6'h32) ? 11'(850 + 10 * c) : 11'(1350 + 25 * (c - 6'h32));
    endfunction
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial begin
        reset = 1'b1;
        pf_n = 1'b1;
        sw_en = 3'h0;
        repeat (4) @(negedge clk_sys);
        // value held while reset is still high, before any code could recompute it
        chk(mv, 11'd1425);
        reset = 1'b0;
        @(negedge clk_sys);
        chk(mv, 11'd1425);
        chk({10'h0, ll}, 11'h1);
        chk({9'h0, l3, l2}, 11'h0);
        h.rd(OFS_BUCK_ONE, d);
        chk({3'h0, d}, 11'hb5);
        h.rd(OFS_PF_DCHG_CFG, d);
        chk({3'h0, d}, 11'h00);
        h.rd(OFS_LIMIT_CFG, d);
        chk({3'h0, d}, {3'h0, RST_LIMIT_CFG});
        chk({10'h0, hyst}, {10'h0, RST_LIMIT_CFG[HYST_BIT]});
        foreach (rows[k]) begin
            h.wr(rows[k].a, rows[k].d);
            h.rd(rows[k].a, d);
            chk({3'h0, d}, {3'h0, rows[k].e});
        end
        // every current limit code on both switches
        for (int c = 0; c < 4; c++) begin
            h.wr(OFS_LIMIT_CFG, 8'(c * 5));
            repeat (2) @(negedge clk_sys);
            chk(m3, ma[c]);
            chk(m2, ma[c]);
        end
        // voltage code held back until committed; boundaries of the map
        foreach (cv[k]) begin
            h.wr(OFS_BUCK_ONE, {2'b00, cv[k]});
            chk({10'h0, ll}, 11'h0);
            chk({5'h0, vc}, k == 0 ? {5'h0, RST_BUCK_ONE[5:0]} : {5'h0, cv[k - 1]});
            h.commit(1'b0);
            chk(mv, exp_mv(cv[k]));
        end
        h.commit(1'b1);
        chk({10'h0, cd}, 11'h1);
        // monitor blanking after a buck write, counted on falling edges
        h.wr(OFS_BUCK_ONE, 8'h80);
        for (i = 0; i < 100 && blank === 1'b1; i++) @(negedge clk_sys);
        chk(11'(i), 11'(BC));
        // power-fail cut-off with switches enabled, then discharge once the switches are disabled
        sw_en = 3'h7;
        h.wr(OFS_PF_DCHG_CFG, 8'h38);
        pf_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({8'h0, sw_on}, 11'h0);
        chk({8'h0, dis}, 11'h0);
        h.wr(OFS_PF_DCHG_CFG, 8'h07);
        repeat (3) @(negedge clk_sys);
        chk({8'h0, sw_on}, 11'h7);
        sw_en = 3'h0;
        repeat (2) @(negedge clk_sys);
        chk({8'h0, dis}, 11'h7);
        pf_n = 1'b1;
        // second reset in mid-run
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(mv, 11'd1425);
        chk({8'h0, dis}, 11'h0);
        reset = 1'b0;
        h.rd(OFS_PF_DCHG_CFG, d);
        chk({3'h0, d}, 11'h00);
        chk(mv, 11'd1425);
        give_verdict();
    end
    // guards against a hung sequence
    initial begin
        repeat (5000) @(negedge clk_sys);
        num_errors++;
        give_verdict();
    end
endmodule // tb

// file: verilog/sbc_blank_timer.sv
`timescale 1ns/1ps
// holds active for CYCLES cycles after the last start; a new start restarts it
module sbc_blank_timer #(
    parameter int CYCLES = 125000,
    parameter int CW = 17
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    output logic active
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // reload on start, else count down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = CW'(CYCLES);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign active = (cnt_r != '0);
endmodule // sbc_blank_timer

// file: verilog/sbc_cfg_regs.sv
`timescale 1ns/1ps
module sbc_cfg_regs #(
    parameter int BLANK_CYC = sbc_pkg::BLANK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic power_fail_out_n,
    input wire logic [2:0] sw_enable,
    output logic [2:0] sw_on,
    output logic [2:0] sw_discharge,
    output logic [1:0] third_switch_current_limit,
    output logic [1:0] second_switch_current_limit,
    output logic [10:0] third_limit_ma,
    output logic [10:0] second_limit_ma,
    output logic undervoltage_hysteresis_sel,
    output logic buck_light_load,
    output logic [5:0] buck_vcode,
    output logic [10:0] buck_vout_mv,
    output logic buck_commit_discharge,
    output logic buck_monitor_blank
);
    import sbc_pkg::*;

    localparam int BW = $clog2(BLANK_CYC + 1);

    function automatic logic [10:0] ilim_ma(input logic [1:0] code);
        logic [10:0] v;
        unique case (code)
            2'b00: v = ILIM_MA_0;
            2'b01: v = ILIM_MA_1;
            2'b10: v = ILIM_MA_2;
            2'b11: v = ILIM_MA_3;
        endcase
        return v;
    endfunction

    function automatic logic [10:0] vcode_mv(input logic [5:0] code);
        logic [10:0] v;
        if (code <= VCODE_KNEE) begin
            v = MV_BASE + 11'(MV_STEP_FINE * 11'(code));
        end else begin
            v = MV_KNEE + 11'(MV_STEP_COARSE * 11'(code - VCODE_KNEE));
        end
        return v;
    endfunction

    logic [7:0] lim_cfg_r, lim_cfg_nxt;
    logic [7:0] pf_cfg_r, pf_cfg_nxt;
    logic [7:0] buck_r, buck_nxt;
    logic [5:0] vcode_r, vcode_nxt;
    logic [10:0] mv_r, mv_nxt;
    logic [10:0] lim3_ma_r, lim3_ma_nxt;
    logic [10:0] lim2_ma_r, lim2_ma_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [2:0] on_r, on_nxt;
    logic [2:0] dchg_r, dchg_nxt;
    logic cdis_r, cdis_nxt;
    logic pf_meta_r, pf_sync_r;
    logic pf_active;
    logic wr_buck;
    logic wr_commit;
    logic commit_any;

    // the pin is asynchronous to us, so two flops before anything looks at it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pf_meta_r <= 1'b1;
            pf_sync_r <= 1'b1;
        end else begin
            pf_meta_r <= power_fail_out_n;
            pf_sync_r <= pf_meta_r;
        end
    end
    assign pf_active = !pf_sync_r;

    assign wr_buck = reg_wr && (reg_addr == OFS_BUCK_ONE);
    assign wr_commit = reg_wr && (reg_addr == OFS_COMMIT);
    assign commit_any = wr_commit && (reg_wdata[COMMIT_BIT] || reg_wdata[COMMIT_DCHG_BIT]);

    // register writes, read mux and derived outputs
    always_comb begin
        lim_cfg_nxt = lim_cfg_r;
        pf_cfg_nxt = pf_cfg_r;
        buck_nxt = buck_r;
        vcode_nxt = vcode_r;
        cdis_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_LIMIT_CFG: lim_cfg_nxt = reg_wdata & WMASK_LIMIT_CFG;
                OFS_PF_DCHG_CFG: pf_cfg_nxt = reg_wdata & WMASK_PF_DCHG_CFG;
                OFS_BUCK_ONE: buck_nxt = reg_wdata & WMASK_BUCK_ONE;
                default: ;
            endcase
        end
        // only a commit moves the stored code onto the rail
        if (commit_any) begin
            vcode_nxt = buck_r[5:0];
            cdis_nxt = reg_wdata[COMMIT_DCHG_BIT];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_LIMIT_CFG: rdata_nxt = lim_cfg_r;
                OFS_PF_DCHG_CFG: rdata_nxt = pf_cfg_r;
                OFS_BUCK_ONE: rdata_nxt = buck_r;
                default: rdata_nxt = 8'h00; // commit bits self-clear, unmapped reads zero
            endcase
        end
        // cut-off only bites while the power-fail pin is low
        on_nxt = sw_enable & ~(pf_cfg_r[CUTOFF_LSB +: 3] & {3{pf_active}});
        dchg_nxt = pf_cfg_r[DCHG_LSB +: 3] & ~on_nxt;
        mv_nxt = vcode_mv(vcode_nxt);
        lim3_ma_nxt = ilim_ma(lim_cfg_r[THIRD_LIM_LSB +: 2]);
        lim2_ma_nxt = ilim_ma(lim_cfg_r[SECOND_LIM_LSB +: 2]);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lim_cfg_r <= RST_LIMIT_CFG;
            pf_cfg_r <= RST_PF_DCHG_CFG;
            buck_r <= RST_BUCK_ONE;
            vcode_r <= RST_BUCK_ONE[5:0];
            mv_r <= vcode_mv(RST_BUCK_ONE[5:0]);
            lim3_ma_r <= ILIM_MA_0;
            lim2_ma_r <= ILIM_MA_0;
            rdata_r <= 8'h00;
            on_r <= 3'h0;
            dchg_r <= 3'h0;
            cdis_r <= 1'b0;
        end else begin
            lim_cfg_r <= lim_cfg_nxt;
            pf_cfg_r <= pf_cfg_nxt;
            buck_r <= buck_nxt;
            vcode_r <= vcode_nxt;
            mv_r <= mv_nxt;
            lim3_ma_r <= lim3_ma_nxt;
            lim2_ma_r <= lim2_ma_nxt;
            rdata_r <= rdata_nxt;
            on_r <= on_nxt;
            dchg_r <= dchg_nxt;
            cdis_r <= cdis_nxt;
        end
    end

    // restart on every buck register write, even one that leaves the value unchanged
    sbc_blank_timer #(
        .CYCLES(BLANK_CYC),
        .CW(BW)
    ) u_blank (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(wr_buck),
        .active(buck_monitor_blank)
    );

    assign reg_rdata = rdata_r;
    assign sw_on = on_r;
    assign sw_discharge = dchg_r;
    assign third_switch_current_limit = lim_cfg_r[THIRD_LIM_LSB +: 2];
    assign second_switch_current_limit = lim_cfg_r[SECOND_LIM_LSB +: 2];
    assign third_limit_ma = lim3_ma_r;
    assign second_limit_ma = lim2_ma_r;
    assign undervoltage_hysteresis_sel = lim_cfg_r[HYST_BIT];
    assign buck_light_load = buck_r[LIGHT_LOAD_BIT];
    assign buck_vcode = vcode_r;
    assign buck_vout_mv = mv_r;
    assign buck_commit_discharge = cdis_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_buck_write;
        reg_wr && reg_addr == OFS_BUCK_ONE;
    endsequence
    sequence s_blank_hold;
        buck_monitor_blank [*8];
    endsequence

    a_reset_values: assert property ($past(reset) |-> lim_cfg_r == 8'h40 && pf_cfg_r == 8'h00
        && buck_r == 8'hb5 && buck_vout_mv == 11'd1425) else $error("bad reset value");
    a_third_ilim: assert property (third_switch_current_limit == 2'b11
        |=> third_limit_ma == 11'd1000) else $error("third limit map wrong");
    a_second_ilim: assert property (second_switch_current_limit == 2'b01
        |=> second_limit_ma == 11'd200) else $error("second limit map wrong");
    a_pf_cutoff: assert property (pf_active && pf_cfg_r[5] |=> !sw_on[2])
        else $error("switch not cut off");
    a_pf_ignored: assert property (!pf_cfg_r[4] |=> sw_on[1] == $past(sw_enable[1]))
        else $error("switch touched by power fail");
    a_dchg_apply: assert property ($past(pf_cfg_r[0]) && !sw_on[0] |-> sw_discharge[0])
        else $error("no discharge when off");
    a_dchg_block: assert property (!$past(pf_cfg_r[1]) |-> !sw_discharge[1])
        else $error("discharge while disabled");
    a_reserved_zero: assert property (reg_rd && reg_addr == OFS_PF_DCHG_CFG
        |=> reg_rdata[7:6] == 2'b00) else $error("reserved bits nonzero");
    a_blank_start: assert property (s_buck_write |=> s_blank_hold)
        else $error("monitor not blanked");
    a_commit_hold: assert property (!commit_any |=> $stable(buck_vcode))
        else $error("code applied without commit");
    a_commit_apply: assert property (commit_any |=> buck_vcode == $past(buck_r[5:0]))
        else $error("commit did not apply code");
    a_mode_bit: assert property (s_buck_write |=> buck_light_load == $past(reg_wdata[7]))
        else $error("mode bit not stored");
    a_vout_knee: assert property (buck_vcode == 6'h32 |-> buck_vout_mv == 11'd1350)
        else $error("knee voltage wrong");
    a_vout_top: assert property (buck_vcode == 6'h3f |-> buck_vout_mv == 11'd1675)
        else $error("top voltage wrong");
endmodule // sbc_cfg_regs

// file: verilog/sbc_pkg.sv
package sbc_pkg;
    // register offsets on the management port
    localparam logic [7:0] OFS_LIMIT_CFG = 8'h14;
    localparam logic [7:0] OFS_PF_DCHG_CFG = 8'h15;
    localparam logic [7:0] OFS_BUCK_ONE = 8'h16;
    localparam logic [7:0] OFS_COMMIT = 8'h1a;

    // reset values
    localparam logic [7:0] RST_LIMIT_CFG = 8'h40;
    localparam logic [7:0] RST_PF_DCHG_CFG = 8'h00;
    localparam logic [7:0] RST_BUCK_ONE = 8'hb5;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] WMASK_LIMIT_CFG = 8'h4f;
    localparam logic [7:0] WMASK_PF_DCHG_CFG = 8'h3f;
    localparam logic [7:0] WMASK_BUCK_ONE = 8'hbf;

    // field positions
    localparam int HYST_BIT = 6;
    localparam int THIRD_LIM_LSB = 2;
    localparam int SECOND_LIM_LSB = 0;
    localparam int CUTOFF_LSB = 3;
    localparam int DCHG_LSB = 0;
    localparam int LIGHT_LOAD_BIT = 7;
    localparam int COMMIT_BIT = 0;
    localparam int COMMIT_DCHG_BIT = 1;

    // voltage code map
    localparam logic [5:0] VCODE_KNEE = 6'h32;
    localparam logic [10:0] MV_BASE = 11'd850;
    localparam logic [10:0] MV_KNEE = 11'd1350;
    localparam logic [10:0] MV_STEP_FINE = 11'd10;
    localparam logic [10:0] MV_STEP_COARSE = 11'd25;

    // current limit selections in mA
    localparam logic [10:0] ILIM_MA_0 = 11'd100;
    localparam logic [10:0] ILIM_MA_1 = 11'd200;
    localparam logic [10:0] ILIM_MA_2 = 11'd500;
    localparam logic [10:0] ILIM_MA_3 = 11'd1000;

    // monitor blanking after a buck write
    localparam int CLK_MHZ = 25;
    localparam int BLANK_TIME_US = 5000;
    localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_MHZ;
endpackage
